/* File: rtl/ebaw_pkg.sv */
// Shared types and constants for the external bus alignment and wait block
package ebaw_pkg;

  localparam int unsigned AREA_N = 4;
  localparam int unsigned LINE_W = 16;

  // Access sizes of a request
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_LONG = 2'h2;

  // Data-cycle wait modes
  localparam logic [1:0] WM_PROG = 2'h0;
  localparam logic [1:0] WM_NONE = 2'h1;
  localparam logic [1:0] WM_PIN  = 2'h2;
  localparam logic [1:0] WM_AUTO = 2'h3;

  // Values after reset
  localparam logic [1:0] WCNT_RST = 2'h3;

  // Lane masks on the sixteen data lines
  localparam logic [15:0] LANE_NONE = 16'h0000;
  localparam logic [15:0] LANE_HI   = 16'hFF00;
  localparam logic [15:0] LANE_ALL  = 16'hFFFF;

  // Address cycle length before the optional address wait, in states
  localparam logic [2:0] ADR_STATES = 3'h2;

  typedef struct packed {
    logic       area_three_state_sel;
    logic       area_addr_wait_sel;
    logic       area_bus_width_sel;   // 1: 16-bit area, 0: 8-bit area
    logic       area_wait_mode_hi;
    logic       area_wait_mode_lo;
    logic       area_wait_count_hi;
    logic       area_wait_count_lo;
  } ebaw_area_cfg_t;

  localparam ebaw_area_cfg_t CFG_RST = '{area_three_state_sel: 1'b1, area_addr_wait_sel: 1'b0,
                                         area_bus_width_sel: 1'b1, area_wait_mode_hi: WM_PROG[1],
                                         area_wait_mode_lo: WM_PROG[0], area_wait_count_hi: WCNT_RST[1],
                                         area_wait_count_lo: WCNT_RST[0]};

  typedef struct packed {
    logic [1:0]  area;
    logic [23:0] addr;
    logic [1:0]  size;
    logic        write;
    logic [31:0] wdata;
  } ebaw_req_t;

  localparam int unsigned REQ_W = $bits(ebaw_req_t);

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ADR  = 6'h02,
    ST_D1   = 6'h04,
    ST_D2   = 6'h08,
    ST_TW   = 6'h10,
    ST_D3   = 6'h20
  } ebaw_state_t;

endpackage : ebaw_pkg

/* File: rtl/ebaw_fifo.sv */
// Request FIFO with valid/ready on both sides
`timescale 1ns/1ps
module ebaw_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk_sys_i,
  input  wire logic             sys_rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
    logic                        full;
    logic                        empty;
    logic                        rdy;
  } ebaw_fifo_st_t;

  ebaw_fifo_st_t s_r;
  ebaw_fifo_st_t s_nxt;
  logic          push;
  logic          pop;

  assign in_ready_o  = s_r.rdy;
  assign out_valid_o = !s_r.empty;
  assign out_data_o  = s_r.mem[s_r.rp];

  always_comb begin
    s_nxt = s_r;
    push  = in_valid_i && !s_r.full;
    pop   = out_ready_i && !s_r.empty;
    if (push) begin
      s_nxt.mem[s_r.wp] = in_data_i;
      s_nxt.wp = (s_r.wp == AW'(DEPTH - 1)) ? '0 : s_r.wp + 1'b1;
    end
    if (pop) begin
      s_nxt.rp = (s_r.rp == AW'(DEPTH - 1)) ? '0 : s_r.rp + 1'b1;
    end
    if (push && !pop) begin
      s_nxt.cnt = s_r.cnt + 1'b1;
    end else if (pop && !push) begin
      s_nxt.cnt = s_r.cnt - 1'b1;
    end
    s_nxt.full  = (s_nxt.cnt == (AW + 1)'(DEPTH));
    s_nxt.empty = (s_nxt.cnt == '0);
    // Ready is kept as a flop so the port comes straight from a register
    s_nxt.rdy   = !s_nxt.full;
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      s_r       <= '0;
      s_r.empty <= 1'b1;
      s_r.rdy   <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule : ebaw_fifo

/* File: rtl/ebaw_sync3.sv */
// Three-stage pin synchroniser; the level follows once stages two and three agree
`timescale 1ns/1ps
module ebaw_sync3 #(
  parameter logic RST_VAL = 1'b1
) (
  input  wire logic clk_sys_i,
  input  wire logic sys_rst_i,
  input  wire logic pin_i,
  output logic      level_o
);
  typedef struct packed {
    logic q1;
    logic q2;
    logic q3;
    logic lvl;
  } ebaw_sync_st_t;

  ebaw_sync_st_t s_r;
  ebaw_sync_st_t s_nxt;

  assign level_o = s_r.lvl;

  always_comb begin
    s_nxt    = s_r;
    s_nxt.q1 = pin_i;
    s_nxt.q2 = s_r.q1;
    s_nxt.q3 = s_r.q2;
    if (s_r.q2 == s_r.q3) begin
      s_nxt.lvl = s_r.q3;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      s_r <= {4{RST_VAL}};
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule : ebaw_sync3

/* File: rtl/ebaw_top.sv */
// External bus data alignment, strobe and wait state controller
// Behaviour
// - Sixteen address output lines at most.
// - Normal mode address pins drive only where their direction bit is 1.
// - Multiplexed 16-bit area: address cycle puts address bits 15..0 on all shared lines.
// - Multiplexed 8-bit area: address bits 7..0 go on upper eight shared lines.
// - Multiplexed address cycle width follows the area bus width.
// - 8-bit area: one byte per cycle, upper lane; word two, longword four cycles.
// - 16-bit area: byte or word per cycle; longword as two word cycles.
// - 16-bit byte access: even address upper lane, odd address lower lane.
// - Read strobe covers both lanes; upper/lower write strobes per lane, both for words.
// - Byte write to 16-bit area drives filler on unused lane, its strobe idle.
// - Byte read from 16-bit area leaves unused lane input, value dropped.
// - 8-bit area never drives or uses the lower eight data lines.
// - Multiplexed 8-bit area uses upper eight lines for address and data.
// - Multiplexed 2-state data space takes no data waits; 3-state may.
// - Program wait mode inserts exactly the programmed waits after the second state.
// - Pin wait mode adds programmed waits plus one per low wait sample.
// - Auto-wait samples wait once at last second state; low gives programmed count only.
// - Reset: all areas 3-state, three program waits, wait pin ignored.
// - Per-area bit picks 2-state or 3-state; 2-state forbids waits.
// - Multiplexed address cycle is two states plus optional one address wait.
// - Per-area bit picks 8 or 16 bit width, same for address and data.
// - Per-area two-bit count selects zero to three data waits.
`timescale 1ns/1ps
module ebaw_top
  import ebaw_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH = 8
) (
  input  wire logic           clk_sys_i,
  input  wire logic           sys_rst_i,
  input  wire logic           req_valid_i,
  output logic                req_ready_o,
  input  wire ebaw_req_t      req_i,
  output logic                rsp_valid_o,
  output logic      [31:0]    rsp_rdata_o,
  output logic                busy_o,
  input  wire logic           cfg_we_i,
  input  wire logic [1:0]     cfg_area_i,
  input  wire ebaw_area_cfg_t cfg_wdata_i,
  input  wire logic           mux_mode_i,
  input  wire logic [15:0]    addr_dir_i,
  output logic      [15:0]    address_lines_o,
  output logic      [15:0]    address_lines_oe_o,
  output logic      [15:0]    data_lines_o,
  output logic      [15:0]    data_lines_oe_o,
  input  wire logic [15:0]    data_lines_i,
  output logic                rd_strobe_n_o,
  output logic                upper_write_strobe_n_o,
  output logic                lower_write_strobe_n_o,
  output logic                addr_hold_n_o,
  input  wire logic           ext_wait_n_i
);

  typedef struct packed {
    ebaw_state_t                      st;
    ebaw_req_t                        req;
    logic [1:0]                       beat;
    logic [1:0]                       last;
    logic [2:0]                       cnt;
    logic [AREA_N-1:0][6:0]           cfg;
    logic [15:0]                      baddr;
    logic [15:0]                      a_o;
    logic [15:0]                      a_oe;
    logic [15:0]                      d_o;
    logic [15:0]                      d_oe;
    logic                             rd_n;
    logic                             uw_n;
    logic                             lw_n;
    logic                             hold_n;
    logic                             rsp_v;
    logic                             busy;
    logic [31:0]                      rdata;
  } ebaw_st_t;

  ebaw_st_t       s_r;
  ebaw_st_t       s_nxt;
  ebaw_req_t      q_data;
  logic           q_valid;
  logic           q_pop;
  logic           wait_lvl;
  logic           wait_low;
  ebaw_area_cfg_t c;
  ebaw_area_cfg_t cn;
  logic [1:0]     wmode;
  logic [1:0]     wcnt;
  logic           done;
  logic           strobe_st;
  logic [31:0]    wsh;

  // Requests queue here so the CPU side sees back-pressure only once FIFO_DEPTH requests wait
  ebaw_fifo #(
    .WIDTH (REQ_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_i   (clk_sys_i),
    .sys_rst_i   (sys_rst_i),
    .in_valid_i  (req_valid_i),
    .in_ready_o  (req_ready_o),
    .in_data_i   (req_i),
    .out_valid_o (q_valid),
    .out_ready_i (q_pop),
    .out_data_o  (q_data)
  );

  ebaw_sync3 #(
    .RST_VAL (1'b1)
  ) u_wait_sync (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .pin_i     (ext_wait_n_i),
    .level_o   (wait_lvl)
  );

  assign wait_low = !wait_lvl;
  assign rsp_valid_o            = s_r.rsp_v;
  assign rsp_rdata_o            = s_r.rdata;
  assign busy_o                 = s_r.busy;
  assign address_lines_o        = s_r.a_o;
  assign address_lines_oe_o     = s_r.a_oe;
  assign data_lines_o           = s_r.d_o;
  assign data_lines_oe_o        = s_r.d_oe;
  assign rd_strobe_n_o          = s_r.rd_n;
  assign upper_write_strobe_n_o = s_r.uw_n;
  assign lower_write_strobe_n_o = s_r.lw_n;
  assign addr_hold_n_o          = s_r.hold_n;

  always_comb begin
    s_nxt       = s_r;
    s_nxt.rsp_v = 1'b0;
    q_pop       = 1'b0;
    done        = 1'b0;
    c           = ebaw_area_cfg_t'(s_r.cfg[s_r.req.area]);
    wmode       = {c.area_wait_mode_hi, c.area_wait_mode_lo};
    wcnt        = {c.area_wait_count_hi, c.area_wait_count_lo};
    if (cfg_we_i) begin
      s_nxt.cfg[cfg_area_i] = cfg_wdata_i;
    end
    unique case (s_r.st)
      ST_IDLE: begin
        if (q_valid) begin
          q_pop      = 1'b1;
          s_nxt.req  = q_data;
          s_nxt.beat = 2'h0;
          s_nxt.rdata = 32'h0000_0000;
          cn = ebaw_area_cfg_t'(s_r.cfg[q_data.area]);
          if (cn.area_bus_width_sel) begin
            s_nxt.last = (q_data.size == SZ_LONG) ? 2'h1 : 2'h0;
          end else begin
            s_nxt.last = (q_data.size == SZ_LONG) ? 2'h3 : ((q_data.size == SZ_WORD) ? 2'h1 : 2'h0);
          end
          s_nxt.cnt = ADR_STATES - 3'h1 + {2'h0, cn.area_addr_wait_sel};
          s_nxt.st  = mux_mode_i ? ST_ADR : ST_D1;
        end
      end
      ST_ADR: begin
        if (s_r.cnt == 3'h0) begin
          s_nxt.st = ST_D1;
        end else begin
          s_nxt.cnt = s_r.cnt - 3'h1;
        end
      end
      ST_D1: begin
        s_nxt.st = ST_D2;
      end
      ST_D2: begin
        // 2-state areas never stretch, whatever the wait mode says
        if (!c.area_three_state_sel) begin
          done = 1'b1;
        end else begin
          s_nxt.st = ST_D3;
          unique case (wmode)
            WM_PROG: begin
              if (wcnt != 2'h0) begin
                s_nxt.st  = ST_TW;
                s_nxt.cnt = {1'b0, wcnt};
              end
            end
            WM_PIN: begin
              if (wcnt != 2'h0 || wait_low) begin
                s_nxt.st  = ST_TW;
                s_nxt.cnt = (wcnt == 2'h0) ? 3'h1 : {1'b0, wcnt};
              end
            end
            WM_AUTO: begin
              if (wait_low && wcnt != 2'h0) begin
                s_nxt.st  = ST_TW;
                s_nxt.cnt = {1'b0, wcnt};
              end
            end
            WM_NONE: begin
              s_nxt.st = ST_D3;
            end
          endcase
        end
      end
      ST_TW: begin
        if (s_r.cnt > 3'h1) begin
          s_nxt.cnt = s_r.cnt - 3'h1;
        end else if (!(wmode == WM_PIN && wait_low)) begin
          s_nxt.st = ST_D3;
        end
      end
      ST_D3: begin
        done = 1'b1;
      end
      default: begin
        s_nxt.st = ST_IDLE;
      end
    endcase

    if (done) begin
      if (!s_r.req.write) begin
        if (!c.area_bus_width_sel) begin
          s_nxt.rdata = {s_r.rdata[23:0], data_lines_i[15:8]};
        end else if (s_r.req.size == SZ_BYTE) begin
          // Lane not addressed is sampled but dropped
          s_nxt.rdata = {s_r.rdata[23:0], s_r.baddr[0] ? data_lines_i[7:0] : data_lines_i[15:8]};
        end else begin
          s_nxt.rdata = {s_r.rdata[15:0], data_lines_i};
        end
      end
      if (s_r.beat == s_r.last) begin
        s_nxt.st    = ST_IDLE;
        s_nxt.rsp_v = 1'b1;
      end else begin
        s_nxt.beat = s_r.beat + 2'h1;
        s_nxt.cnt  = ADR_STATES - 3'h1 + {2'h0, c.area_addr_wait_sel};
        s_nxt.st   = mux_mode_i ? ST_ADR : ST_D1;
      end
    end
    // Pin values follow the next state so that every pin comes from a flop
    cn = ebaw_area_cfg_t'(s_nxt.cfg[s_nxt.req.area]);
    s_nxt.baddr = s_nxt.req.addr[15:0] +
                  (cn.area_bus_width_sel ? {13'h0000, s_nxt.beat, 1'b0} : {14'h0000, s_nxt.beat});
    s_nxt.a_o  = s_nxt.baddr;
    s_nxt.a_oe = mux_mode_i ? LANE_NONE : addr_dir_i;
    strobe_st  = (s_nxt.st == ST_D2) || (s_nxt.st == ST_TW) || (s_nxt.st == ST_D3);
    wsh        = cn.area_bus_width_sel ? (s_nxt.req.wdata >> {s_nxt.last - s_nxt.beat, 4'h0})
                                       : (s_nxt.req.wdata >> {s_nxt.last - s_nxt.beat, 3'h0});
    s_nxt.d_o  = 16'h0000;
    s_nxt.d_oe = LANE_NONE;
    if (s_nxt.st == ST_ADR) begin
      s_nxt.d_o  = cn.area_bus_width_sel ? s_nxt.baddr : {s_nxt.baddr[7:0], 8'h00};
      s_nxt.d_oe = cn.area_bus_width_sel ? LANE_ALL : LANE_HI;
    end else if (s_nxt.req.write && (strobe_st || s_nxt.st == ST_D1)) begin
      if (!cn.area_bus_width_sel) begin
        s_nxt.d_o  = {wsh[7:0], 8'h00};
        s_nxt.d_oe = LANE_HI;
      end else if (s_nxt.req.size == SZ_BYTE) begin
        // Both lanes carry the byte; the unused one is don't-care to the target
        s_nxt.d_o  = {s_nxt.req.wdata[7:0], s_nxt.req.wdata[7:0]};
        s_nxt.d_oe = LANE_ALL;
      end else begin
        s_nxt.d_o  = wsh[15:0];
        s_nxt.d_oe = LANE_ALL;
      end
    end
    s_nxt.rd_n   = !(!s_nxt.req.write && (strobe_st || s_nxt.st == ST_D1));
    s_nxt.uw_n   = !(s_nxt.req.write && strobe_st &&
                     (!cn.area_bus_width_sel || s_nxt.req.size != SZ_BYTE || !s_nxt.baddr[0]));
    s_nxt.lw_n   = !(s_nxt.req.write && strobe_st && cn.area_bus_width_sel &&
                     (s_nxt.req.size != SZ_BYTE || s_nxt.baddr[0]));
    s_nxt.hold_n = !(s_nxt.st == ST_ADR);
    s_nxt.busy   = (s_nxt.st != ST_IDLE);
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      s_r        <= '0;
      s_r.st     <= ST_IDLE;
      s_r.cfg    <= {AREA_N{CFG_RST}};
      s_r.rd_n   <= 1'b1;
      s_r.uw_n   <= 1'b1;
      s_r.lw_n   <= 1'b1;
      s_r.hold_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Checks on the sequencing and lane use
  ebaw_area_cfg_t ac;
  assign ac = ebaw_area_cfg_t'(s_r.cfg[s_r.req.area]);

  sequence adr_entry_s;
    (s_r.st != ST_ADR) ##1 (s_r.st == ST_ADR);
  endsequence

  sequence three_waits_s;
    (s_r.st == ST_TW) [*3] ##1 (s_r.st == ST_D3);
  endsequence

  a_lower_lane_idle: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (s_r.st != ST_IDLE && !ac.area_bus_width_sel) |-> (s_r.d_oe[7:0] == 8'h00 && s_r.lw_n))
    else $error("lower lanes driven in 8-bit area");

  a_addr_dir_gate: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (!$past(sys_rst_i) && !$past(mux_mode_i)) |-> (address_lines_oe_o == $past(addr_dir_i)))
    else $error("address pin driven without direction bit");

  a_mux_addr_wide: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (s_r.st == ST_ADR && ac.area_bus_width_sel) |-> (data_lines_o == s_r.baddr && data_lines_oe_o == LANE_ALL))
    else $error("16-bit address cycle wrong");

  a_mux_addr_narrow: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (s_r.st == ST_ADR && !ac.area_bus_width_sel) |-> (data_lines_o[15:8] == s_r.baddr[7:0] && data_lines_oe_o == LANE_HI))
    else $error("8-bit address cycle wrong");

  a_addr_cycle_len: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (adr_entry_s ##0 ac.area_addr_wait_sel) |-> (s_r.st == ST_ADR) [*3] ##1 (s_r.st == ST_D1))
    else $error("address cycle length wrong");

  a_two_state_nowait: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (s_r.st == ST_D2 && !ac.area_three_state_sel) |=> (s_r.st != ST_TW && s_r.st != ST_D3))
    else $error("wait inserted in 2-state area");

  a_prog_wait_exact: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (s_r.st == ST_D2 && ac.area_three_state_sel && wmode == WM_PROG && wcnt == 2'h3 && !cfg_we_i)
    |=> three_waits_s)
    else $error("program wait count wrong");

  a_auto_wait_bound: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (s_r.st == ST_D2 && ac.area_three_state_sel && wmode == WM_AUTO && wcnt == 2'h3 && wait_low && !cfg_we_i)
    |=> three_waits_s)
    else $error("auto-wait count wrong");

  a_pin_wait_extend: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (s_r.st == ST_TW && s_r.cnt == 3'h1 && wmode == WM_PIN && wait_low) |=> (s_r.st == ST_TW))
    else $error("pin wait not extended");

  a_byte_lane_odd: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (s_r.st == ST_D2 && s_r.req.write && s_r.req.size == SZ_BYTE && ac.area_bus_width_sel && s_r.baddr[0])
    |-> (upper_write_strobe_n_o && !lower_write_strobe_n_o))
    else $error("odd byte strobe wrong");

endmodule : ebaw_top

/* File: tb/ebaw_ext_mem.sv */
// Behavioural external memory on the far side of the aligned bus
`timescale 1ns/1ps
module ebaw_ext_mem (
  input  wire logic        clk_sys_i,
  input  wire logic        bus16_i,
  input  wire logic        mux_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [15:0] dq_i,
  input  wire logic        rd_n_i,
  input  wire logic        hwr_n_i,
  input  wire logic        lwr_n_i,
  input  wire logic        ah_n_i,
  output logic      [15:0] dq_o
);
  logic [7:0]  mem [0:65535];
  logic [15:0] lat_r = 16'h0000;
  logic [15:0] last_r = 16'h0000;
  logic [15:0] adr;
  logic [15:0] hi_a;
  logic [15:0] lo_a;
  assign adr  = mux_i ? lat_r : addr_i;
  assign hi_a = bus16_i ? {adr[15:1], 1'h0} : adr;
  assign lo_a = {adr[15:1], 1'h1};
  // Released lines show the inverse of the last value, so stale data never passes
  always_comb begin
    dq_o = ~last_r;
    if (!rd_n_i) begin
      dq_o[15:8] = mem[hi_a];
      if (bus16_i) dq_o[7:0] = mem[lo_a];
    end
  end
  always @(posedge clk_sys_i) begin
    last_r <= dq_o;
    if (!ah_n_i) lat_r <= bus16_i ? dq_i : {8'h00, dq_i[15:8]};
    if (!hwr_n_i) mem[hi_a] <= dq_i[15:8];
    if (!lwr_n_i && bus16_i) mem[lo_a] <= dq_i[7:0];
  end
endmodule : ebaw_ext_mem

/* File: tb/ebaw_top_bench.sv */
// Self-checking bench for the external bus alignment and wait block
`timescale 1ns/1ps
module ebaw_top_bench;
  import ebaw_pkg::*;
  logic clk_sys_i = 1'h0;
  logic sys_rst_i = 1'h1;
  logic req_valid = 1'h0;
  logic rdy, rsp_v, busy, rdn, hwn, lwn, ahn, cfg_we = 1'h0, mux = 1'h0, far16 = 1'h1, wait_n = 1'h1;
  ebaw_req_t req = '0;
  ebaw_area_cfg_t cfg_wd = CFG_RST;
  logic [1:0]  cfg_a = 2'h0;
  logic [15:0] dir = 16'h0F0F;
  logic [15:0] adr, adr_oe, dq_o, dq_oe, dq_i, ah_val;
  logic [31:0] rsp_d, rdat;
  int failures = 0, checks = 0, rd_cyc, hw_cyc, lw_cyc, lo_oe, ah_cyc, bz_cyc;
  always #20 clk_sys_i = ~clk_sys_i;
  ebaw_top u_ebaw_top (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .req_valid_i(req_valid),
    .req_ready_o(rdy), .req_i(req), .rsp_valid_o(rsp_v), .rsp_rdata_o(rsp_d), .busy_o(busy),
    .cfg_we_i(cfg_we), .cfg_area_i(cfg_a), .cfg_wdata_i(cfg_wd), .mux_mode_i(mux), .addr_dir_i(dir),
    .address_lines_o(adr), .address_lines_oe_o(adr_oe), .data_lines_o(dq_o), .data_lines_oe_o(dq_oe),
    .data_lines_i(dq_i), .rd_strobe_n_o(rdn), .upper_write_strobe_n_o(hwn), .lower_write_strobe_n_o(lwn),
    .addr_hold_n_o(ahn), .ext_wait_n_i(wait_n));
  ebaw_ext_mem u_ebaw_ext_mem (.clk_sys_i(clk_sys_i), .bus16_i(far16), .mux_i(mux), .addr_i(adr),
    .dq_i(dq_o), .rd_n_i(rdn), .hwr_n_i(hwn), .lwr_n_i(lwn), .ah_n_i(ahn), .dq_o(dq_i));
  // Strobe and lane activity seen on the pins during one request
  always @(posedge clk_sys_i) begin
    if (rdn === 1'h0) rd_cyc++;
    if (busy === 1'h1) bz_cyc++;
    if (hwn === 1'h0) hw_cyc++;
    if (lwn === 1'h0) lw_cyc++;
    if (dq_oe[7:0] !== 8'h00) lo_oe++;
    if (ahn === 1'h0) begin
      ah_cyc++;
      ah_val = dq_o;
    end
  end
  function automatic logic [7:0] pat(input int i);
    return 8'(i * 29 + 60);
  endfunction : pat
  task automatic chk(input bit ok, input string msg);
    checks++;
    if (!ok) begin
      failures++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : chk
  task automatic close_out;
    $display("failures=%0d checks=%0d", failures, checks);
    if (failures == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out
  task automatic cfg(input logic [1:0] a, input logic ts, aw, b16, input logic [1:0] wm, wc);
    @(posedge clk_sys_i);
    cfg_we <= 1'h1;
    cfg_a  <= a;
    cfg_wd <= {ts, aw, b16, wm, wc};
    far16  <= b16;
    @(posedge clk_sys_i);
    cfg_we <= 1'h0;
  endtask : cfg
  task automatic acc(input logic [1:0] a, input logic [23:0] ad, input logic [1:0] sz, input logic wr,
                     input logic [31:0] wd);
    int n;
    @(posedge clk_sys_i);
    req_valid <= 1'h1;
    req <= '{area: a, addr: ad, size: sz, write: wr, wdata: wd};
    {rd_cyc, hw_cyc, lw_cyc, lo_oe, ah_cyc, bz_cyc} = '0;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (rdy !== 1'h1 && n < 50);
    req_valid <= 1'h0;
    n = 0;
    while (rsp_v !== 1'h1 && n < 300) begin
      @(posedge clk_sys_i);
      n++;
    end
    chk(n < 300, "no response");
    rdat = rsp_d;
  endtask : acc
  task automatic s_reset;
    repeat (6) @(posedge clk_sys_i);
    chk({rdn, hwn, lwn} === 3'h7 && adr_oe === 16'h0000 && dq_oe === 16'h0000, "idle in reset");
    sys_rst_i <= 1'h0;
    repeat (3) @(posedge clk_sys_i);
    chk(adr_oe === 16'h0F0F && rdy === 1'h1, "address enables");
    dir <= 16'hFFFF;
  endtask : s_reset
  task automatic s_waits;
    wait_n <= 1'h0;
    acc(2'h0, 24'h000100, SZ_WORD, 1'h0, 32'h0);
    chk(rd_cyc == 6 && rdat[15:0] === {pat(256), pat(257)}, "default read");
    for (int w = 0; w < 4; w++) begin
      cfg(2'h1, 1'h1, 1'h0, 1'h1, WM_PROG, 2'(w));
      acc(2'h1, 24'h000102, SZ_WORD, 1'h0, 32'h0);
      chk(rd_cyc == 3 + w, "program waits");
    end
    cfg(2'h1, 1'h1, 1'h0, 1'h1, WM_NONE, 2'h3);
    acc(2'h1, 24'h000102, SZ_WORD, 1'h0, 32'h0);
    chk(rd_cyc == 3, "no-wait mode");
    cfg(2'h1, 1'h0, 1'h0, 1'h1, WM_PIN, 2'h3);
    acc(2'h1, 24'h000102, SZ_WORD, 1'h0, 32'h0);
    chk(rd_cyc == 2, "two-state waits");
    cfg(2'h1, 1'h1, 1'h0, 1'h1, WM_AUTO, 2'h3);
    acc(2'h1, 24'h000102, SZ_WORD, 1'h0, 32'h0);
    chk(rd_cyc == 6, "auto wait low");
    cfg(2'h1, 1'h1, 1'h0, 1'h1, WM_PIN, 2'h1);
    fork
      acc(2'h1, 24'h000104, SZ_WORD, 1'h0, 32'h0);
      repeat (20) @(posedge clk_sys_i);
    join_any
    wait_n <= 1'h1;
    @(posedge rsp_v);
    chk(rd_cyc > 10 && rd_cyc < 30, "pin wait stretch");
    repeat (6) @(posedge clk_sys_i);
    acc(2'h1, 24'h000104, SZ_WORD, 1'h0, 32'h0);
    chk(rd_cyc == 4, "pin wait high");
    cfg(2'h1, 1'h1, 1'h0, 1'h1, WM_AUTO, 2'h2);
    acc(2'h1, 24'h000104, SZ_WORD, 1'h0, 32'h0);
    chk(rd_cyc == 3, "auto wait high");
  endtask : s_waits
  task automatic s_lanes16;
    cfg(2'h1, 1'h1, 1'h0, 1'h1, WM_PROG, 2'h0);
    acc(2'h1, 24'h000200, SZ_BYTE, 1'h1, 32'hA5);
    chk(hw_cyc > 0 && lw_cyc == 0, "even byte lane");
    acc(2'h1, 24'h000201, SZ_BYTE, 1'h1, 32'h5A);
    chk(lw_cyc > 0 && hw_cyc == 0, "odd byte lane");
    acc(2'h1, 24'h000200, SZ_WORD, 1'h0, 32'h0);
    chk(rdat[15:0] === 16'hA55A, "byte writes merged");
    acc(2'h1, 24'h000201, SZ_BYTE, 1'h0, 32'h0);
    chk(rdat[7:0] === 8'h5A, "odd byte read");
    acc(2'h1, 24'h000204, SZ_LONG, 1'h1, 32'h89ABCDEF);
    chk(hw_cyc == 4 && lw_cyc == 4, "long as two words");
    acc(2'h1, 24'h000204, SZ_LONG, 1'h0, 32'h0);
    chk(rdat === 32'h89ABCDEF && rd_cyc == 6 && bz_cyc == 6, "long read order");
  endtask : s_lanes16
  task automatic s_lanes8;
    cfg(2'h2, 1'h1, 1'h0, 1'h0, WM_PROG, 2'h0);
    acc(2'h2, 24'h000300, SZ_LONG, 1'h1, 32'h11223344);
    chk(hw_cyc == 8 && lw_cyc == 0 && lo_oe == 0, "narrow long write");
    acc(2'h2, 24'h000300, SZ_LONG, 1'h0, 32'h0);
    chk(rdat === 32'h11223344 && rd_cyc == 12, "narrow long read");
    acc(2'h2, 24'h000311, SZ_WORD, 1'h0, 32'h0);
    chk(rdat[15:0] === {pat(785), pat(786)} && lo_oe == 0, "narrow word read");
  endtask : s_lanes8
  task automatic s_mux;
    mux <= 1'h1;
    wait_n <= 1'h0;
    cfg(2'h3, 1'h0, 1'h1, 1'h1, WM_PIN, 2'h3);
    acc(2'h3, 24'h000120, SZ_WORD, 1'h0, 32'h0);
    chk(ah_cyc == 3 && ah_val === 16'h0120 && rd_cyc == 2 && bz_cyc == 5, "wide address cycle");
    chk(rdat[15:0] === {pat(288), pat(289)} && adr_oe === 16'h0000, "wide mux data");
    cfg(2'h3, 1'h1, 1'h0, 1'h0, WM_PROG, 2'h0);
    acc(2'h3, 24'h000033, SZ_BYTE, 1'h0, 32'h0);
    chk(ah_cyc == 2 && ah_val[15:8] === 8'h33 && lo_oe == 0, "narrow address cycle");
    chk(rdat[7:0] === pat(51), "narrow mux data");
  endtask : s_mux
  initial begin
    for (int i = 0; i < 65536; i++) u_ebaw_ext_mem.mem[i] = pat(i);
    s_reset();
    s_waits();
    s_lanes16();
    s_lanes8();
    s_mux();
    close_out();
  end
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    failures++;
    close_out();
  end
endmodule : ebaw_top_bench
